// file: sfh_pin_io.sv
// Serial port of the flash: shifting on the serial clock, hold, protect.
// Assumes a host in SPI mode 0 or 3 and pads with pull-ups on the
// write-protect and hold pins, so that a floating pin reads high.
`timescale 1ns/10ps
`include "sfh_map.svh"

module sfh_pin_io #(
	parameter int WORD_W = `SFH_WORD_W,
	parameter int FIFO_DEPTH = `SFH_FIFO_DEPTH
) (
	// Core clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Serial clock from the host.
	input wire logic spi_clk,
	// Pins.
	input wire sfh_pkg::sfh_pins_in_type pins_in,
	output sfh_pkg::sfh_pins_out_type pins_out,
	// Words to send to the host.
	input wire logic [WORD_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Words received from the host.
	output logic [WORD_W-1:0] rx_data,
	output logic rx_valid,
	// Command state from the rest of the device.
	input wire logic dual_mode,
	input wire logic op_busy,
	// Status.
	output sfh_pkg::sfh_status_type status
);
	import sfh_pkg::*;

	// Link domain signals.
	logic hold_rise_reg;
	logic hold_active;
	logic link_run;
	logic dual_s1_reg;
	logic dual_s2_reg;
	logic [WORD_W-1:0] rx_sh_reg;
	logic [WORD_W-1:0] rx_word_reg;
	logic [WORD_W-1:0] rx_word_next;
	logic [2:0] rx_cnt_reg;
	logic rx_tog_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic ack_tog_reg;
	logic [WORD_W-1:0] tx_sh_reg;
	logic [2:0] tx_cnt_reg;
	logic hi_reg;
	logic lo_reg;
	logic drive_reg;
	logic dual_lat_reg;
	logic tx_load;
	logic tx_pend;
	logic hi_oe_n;
	logic lo_oe_n;

	// Core domain signals.
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic hold_s1_reg;
	logic hold_s2_reg;
	logic wp_s1_reg;
	logic wp_s2_reg;
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic rx_prev_reg;
	logic rx_edge_reg;
	logic rx_valid_reg;
	logic [WORD_W-1:0] rx_data_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic req_tog_reg;
	logic [WORD_W-1:0] mbox_word_reg;
	sfh_mbox_type mbox_reg;
	sfh_mbox_type mbox_next;
	sfh_status_type status_reg;
	logic desel;
	logic desel_wide;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic fifo_in_ready;
	logic [WORD_W-1:0] fifo_out_data;

	// Hold follows the pin while the clock is low and freezes while it is
	// high, so hold can only start or end with the clock low.
	assign hold_active = !pins_in.cs_n &&
		(spi_clk ? hold_rise_reg : !pins_in.hold_n);
	assign link_run = pins_in.hold_n;

	// Hold state seen at each rising edge; deselection clears the link.
	always_ff @(posedge spi_clk or posedge pins_in.cs_n) begin
		if (pins_in.cs_n) begin
			hold_rise_reg <= 1'b0;
		end else begin
			hold_rise_reg <= !pins_in.hold_n;
		end
	end

	// Dual mode is a core level, synchronised onto the rising clock.
	always_ff @(posedge spi_clk or posedge pins_in.cs_n) begin
		if (pins_in.cs_n) begin
			dual_s1_reg <= 1'b0;
			dual_s2_reg <= 1'b0;
		end else begin
			dual_s1_reg <= dual_mode;
			dual_s2_reg <= dual_s1_reg;
		end
	end

	// In dual mode the input line is an output, so nothing is received.
	assign rx_word_next = {rx_sh_reg[WORD_W-2:0], pins_in.si};

	// Input bits are taken on rising edges, MSB first; a held edge is
	// skipped so the bit position is kept across the pause.
	always_ff @(posedge spi_clk or posedge pins_in.cs_n) begin
		if (pins_in.cs_n) begin
			rx_sh_reg <= `SFH_WORD_RESET;
			rx_cnt_reg <= `SFH_CNT_RESET;
			rx_word_reg <= `SFH_WORD_RESET;
			rx_tog_reg <= 1'b0;
		end else if (link_run && !dual_s2_reg) begin
			rx_sh_reg <= rx_word_next;
			rx_cnt_reg <= rx_cnt_reg + 3'h1;
			if (rx_cnt_reg == `SFH_RX_LAST) begin
				rx_word_reg <= rx_word_next;
				rx_tog_reg <= !rx_tog_reg;
			end
		end
	end

	// A word waits in the mailbox while request and acknowledge differ.
	assign tx_pend = (req_s2_reg != ack_tog_reg);
	assign tx_load = (tx_cnt_reg == `SFH_CNT_RESET) && tx_pend;

	// Output bits change only on falling edges. Dual words go out MSB pair
	// first, the higher bit of each pair on the high line.
	always_ff @(negedge spi_clk or posedge pins_in.cs_n) begin
		if (pins_in.cs_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			ack_tog_reg <= 1'b0;
			tx_sh_reg <= `SFH_WORD_RESET;
			tx_cnt_reg <= `SFH_CNT_RESET;
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
			drive_reg <= 1'b0;
			dual_lat_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tog_reg;
			req_s2_reg <= req_s1_reg;
			if (!hold_rise_reg) begin
				if (tx_cnt_reg != `SFH_CNT_RESET) begin
					hi_reg <= tx_sh_reg[WORD_W-1];
					lo_reg <= tx_sh_reg[WORD_W-2];
					if (dual_lat_reg) begin
						tx_sh_reg <= {tx_sh_reg[WORD_W-3:0], 2'b00};
					end else begin
						tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
					end
					tx_cnt_reg <= tx_cnt_reg - 3'h1;
				end else if (tx_load) begin
					hi_reg <= mbox_word_reg[WORD_W-1];
					lo_reg <= mbox_word_reg[WORD_W-2];
					ack_tog_reg <= !ack_tog_reg;
					drive_reg <= 1'b1;
					dual_lat_reg <= dual_s2_reg;
					if (dual_s2_reg) begin
						tx_sh_reg <= {mbox_word_reg[WORD_W-3:0], 2'b00};
						tx_cnt_reg <= `SFH_DUAL_SHIFTS;
					end else begin
						tx_sh_reg <= {mbox_word_reg[WORD_W-2:0], 1'b0};
						tx_cnt_reg <= `SFH_SINGLE_SHIFTS;
					end
				end else begin
					drive_reg <= 1'b0;
				end
			end
		end
	end

	// Both lines float when deselected, when held, or with nothing to send.
	assign hi_oe_n =
		!(drive_reg && !pins_in.cs_n && !hold_active);
	assign lo_oe_n =
		!(drive_reg && dual_lat_reg && !pins_in.cs_n &&
		!hold_active);
	assign pins_out = {hi_reg, hi_oe_n, lo_reg, lo_oe_n};

	// Pin levels and link toggles enter the core through two flip-flops.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			hold_s1_reg <= 1'b1;
			hold_s2_reg <= 1'b1;
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
			rx_s1_reg <= 1'b0;
			rx_s2_reg <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= pins_in.cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			hold_s1_reg <= pins_in.hold_n;
			hold_s2_reg <= hold_s1_reg;
			wp_s1_reg <= pins_in.wp_n;
			wp_s2_reg <= wp_s1_reg;
			rx_s1_reg <= rx_tog_reg;
			rx_s2_reg <= rx_s1_reg;
			ack_s1_reg <= ack_tog_reg;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// The link clears its toggles on deselection; that clearing can reach
	// the core a cycle either side of the select level, so a received edge
	// is delayed one cycle and dropped if deselection shows in either.
	assign desel = cs_s2_reg;
	assign desel_wide = cs_s2_reg || cs_s3_reg;

	// Received words are handed on with a one-cycle valid pulse.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_prev_reg <= 1'b0;
			rx_edge_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= `SFH_WORD_RESET;
		end else begin
			rx_prev_reg <= rx_s2_reg;
			rx_edge_reg <= (rx_s2_reg != rx_prev_reg);
			rx_valid_reg <= rx_edge_reg && !desel_wide;
			if (rx_edge_reg && !desel_wide) begin
				rx_data_reg <= rx_word_reg;
			end
		end
	end

	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;

	// Buffer in front of the mailbox; a new frame starts it empty.
	sfh_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(core_clk),
		.rst(sys_rst),
		.clear(desel),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);

	// Words are accepted only while selected; the link drains the buffer.
	assign tx_ready = fifo_in_ready && !desel;
	assign fifo_out_ready = (mbox_reg == SFH_MB_EMPTY) && !desel;

	// Mailbox sequencing: fill, then wait for the link's acknowledge.
	always_comb begin
		mbox_next = mbox_reg;
		case (mbox_reg)
			SFH_MB_EMPTY: begin
				if (fifo_out_valid && !desel) begin
					mbox_next = SFH_MB_WAIT;
				end
			end
			SFH_MB_WAIT: begin
				if (ack_s2_reg == req_tog_reg) begin
					mbox_next = SFH_MB_EMPTY;
				end
			end
			default: begin
				mbox_next = SFH_MB_EMPTY;
			end
		endcase
	end

	// The word stays still while the link may read it.
	always_ff @(posedge core_clk) begin
		if (sys_rst || desel) begin
			mbox_reg <= SFH_MB_EMPTY;
			req_tog_reg <= 1'b0;
			mbox_word_reg <= `SFH_WORD_RESET;
		end else begin
			mbox_reg <= mbox_next;
			if (fifo_out_ready && fifo_out_valid) begin
				mbox_word_reg <= fifo_out_data;
				req_tog_reg <= !req_tog_reg;
			end
		end
	end

	// Status is registered; busy reaches standby whatever hold does.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			status_reg <= '0;
		end else begin
			status_reg.selected <= !desel;
			status_reg.hold_paused <= !desel && !hold_s2_reg;
			status_reg.wp_lock <= (wp_s2_reg == 1'b0);
			status_reg.standby <= desel && !op_busy;
		end
	end

	assign status = status_reg;

endmodule // sfh_pin_io

// file: sfh_map.svh
// Constants for the serial flash pin, shift and hold block.
// Assumes inclusion by the package and the design modules, in that order.
`ifndef SFH_MAP_SVH
`define SFH_MAP_SVH

// Width of one serial data word.
`define SFH_WORD_W 8
// Depth of the transmit buffer in words.
`define SFH_FIFO_DEPTH 4
// Remaining shifts after the first bit of a word is presented.
`define SFH_SINGLE_SHIFTS 3'h7
`define SFH_DUAL_SHIFTS 3'h3
// Reset value of the bit counters.
`define SFH_CNT_RESET 3'h0
// Last bit position of a received word.
`define SFH_RX_LAST 3'h7
// Reset value of the serial data registers.
`define SFH_WORD_RESET 8'h00

`endif

// file: sfh_pkg.sv
// Types shared by the serial flash pin block, its host model, checker and bench.
// Assumes the constants header is on the include path.
`include "sfh_map.svh"

package sfh_pkg;

	// Pins entering the device, apart from the serial clock.
	typedef struct packed {
		logic cs_n;
		logic si;
		logic hold_n;
		logic wp_n;
	} sfh_pins_in_type;

	// Both data lines, each with a value and an active-low enable.
	typedef struct packed {
		logic dual_line_high_o;
		logic dual_line_high_oe_n;
		logic dual_line_low_o;
		logic dual_line_low_oe_n;
	} sfh_pins_out_type;

	// State reported to the rest of the device.
	typedef struct packed {
		logic selected;
		logic hold_paused;
		logic wp_lock;
		logic standby;
	} sfh_status_type;

	// Transmit mailbox state in the core domain.
	typedef enum logic [0:0] {
		SFH_MB_EMPTY = 1'b0,
		SFH_MB_WAIT = 1'b1
	} sfh_mbox_type;

endpackage

// file: sfh_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/10ps

module sfh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	// Filling side.
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Draining side.
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// The extra pointer bit tells a full buffer from an empty one.
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
		(wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

	// Storage is written without reset; only the pointers need one.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers move on accepted pushes and pops; clear empties the buffer.
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule // sfh_fifo

// file: sfh_host.sv
// Behavioural SPI host that drives the serial flash pin block.
// Assumes mode 0 and a 160 ns serial clock that runs only within frames.
`timescale 1ns/10ps

module sfh_host (
	// Host-driven pins.
	output logic spi_clk,
	output logic cs_n,
	output logic si_drv,
	output logic hold_n,
	// Device data lines.
	input wire sfh_pkg::sfh_pins_out_type pins_out
);
	import sfh_pkg::*;
	logic hi_q[$];
	logic lo_q[$];

	// Idle: deselected, clock parked low, hold released.
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		si_drv = 1'b0;
		hold_n = 1'b1;
	end

	// Select edges frame every operation; the input wiggles when idle.
	task automatic frame(input logic sel);
		si_drv = !si_drv;
		#200 cs_n = !sel;
		#200 si_drv = !si_drv;
	endtask

	// One byte MSB first, sampling driven lines on the rise.
	// A pause before bit hp shows that the bit count survives hold.
	task automatic xfer(input logic [7:0] b, input int hp);
		for (int i = 7; i >= 0; i--) begin
			if (i == hp) begin
				hold_n = 1'b0;
				#200 spi_clk = 1'b1;
				si_drv = !si_drv;
				#80 spi_clk = 1'b0;
				#200 hold_n = 1'b1;
				#100;
			end
			si_drv = b[i];
			#80;
			// Lines are read just ahead of the rise, clear of its updates.
			if (!pins_out.dual_line_high_oe_n) begin
				hi_q.push_back(pins_out.dual_line_high_o);
			end
			if (!pins_out.dual_line_low_oe_n) begin
				lo_q.push_back(pins_out.dual_line_low_o);
			end
			spi_clk = 1'b1;
			#80 spi_clk = 1'b0;
		end
	endtask
endmodule // sfh_host

// file: sfh_pin_io_sva.sv
// Port assertions for the serial flash pin block.
// Assumes a bind from the bench; every check runs on the core clock.
`timescale 1ns/10ps

module sfh_pin_io_sva #(
	parameter int WORD_W = 8,
	parameter int FIFO_DEPTH = 4
) (
	// Clocks and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	// Pins.
	input wire sfh_pkg::sfh_pins_in_type pins_in,
	input wire sfh_pkg::sfh_pins_out_type pins_out,
	// Core side.
	input wire logic [WORD_W-1:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [WORD_W-1:0] rx_data,
	input wire logic rx_valid,
	input wire logic dual_mode,
	input wire logic op_busy,
	input wire sfh_pkg::sfh_status_type status
);
	import sfh_pkg::*;
	// Short names for the enables keep the properties readable.
	wire hi_off = pins_out.dual_line_high_oe_n;
	wire lo_off = pins_out.dual_line_low_oe_n;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_float_desel: assert property (
		pins_in.cs_n |-> hi_off && lo_off)
		else $error("Line driven while deselected.");
	a_dual_pair: assert property (!lo_off |-> !hi_off)
		else $error("Low line driven alone.");
	a_hold_float: assert property (
		!pins_in.hold_n && !spi_clk && !pins_in.cs_n |-> hi_off && lo_off)
		else $error("Line driven during hold.");
	a_fall_only: assert property (
		spi_clk && $past(spi_clk) && !pins_in.cs_n && !$past(pins_in.cs_n)
		|-> $stable(pins_out.dual_line_high_o))
		else $error("Output moved while clock high.");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("Receive strobe longer than one cycle.");
	a_no_rx_desel: assert property (pins_in.cs_n [*8] |-> !rx_valid)
		else $error("Word received while deselected.");
	a_desel_seen: assert property (
		pins_in.cs_n [*4] |-> !tx_ready && !status.selected)
		else $error("Deselect not seen.");
	a_sel_seen: assert property ((!pins_in.cs_n) [*5] |-> status.selected)
		else $error("Select not seen.");
	a_busy_awake: assert property (op_busy [*4] |-> !status.standby)
		else $error("Standby during busy.");
	a_standby_idle: assert property (
		(pins_in.cs_n && !op_busy) [*6] |-> status.standby)
		else $error("Standby not reached.");
	a_wp_lock: assert property (
		$stable(pins_in.wp_n) [*5] |-> status.wp_lock == !pins_in.wp_n)
		else $error("Lock does not follow protect pin.");
	a_hold_seen: assert property (
		(!pins_in.hold_n && !pins_in.cs_n) [*5] |-> status.hold_paused)
		else $error("Hold not reported.");

	c_rx: cover property (rx_valid);
	c_hold: cover property (status.hold_paused);
	c_dual: cover property (!lo_off);
endmodule // sfh_pin_io_sva

// file: tb.sv
// Self-checking bench for the serial flash pin block.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) n_tests++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH %0t: got %h want %h", $time, a, e); end

bind sfh_pin_io sfh_pin_io_sva #(.WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH))
	i_sva (.core_clk(core_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
	.pins_in(pins_in), .pins_out(pins_out), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
	.rx_valid(rx_valid), .dual_mode(dual_mode), .op_busy(op_busy),
	.status(status));

module tb;
	import sfh_pkg::*;
	logic core_clk;
	logic sys_rst;
	logic wp_n;
	logic tx_valid;
	logic dual_mode;
	logic op_busy;
	logic [7:0] tx_data;
	logic si_line;
	logic spi_clk, cs_n, si_drv, hold_n, tx_ready, rx_valid;
	logic [7:0] rx_data;
	sfh_pins_in_type pins_in;
	sfh_pins_out_type pins_out;
	sfh_status_type status;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;

	// The shared low line carries the device's bit only while it drives.
	assign si_line = pins_out.dual_line_low_oe_n ? si_drv
		: pins_out.dual_line_low_o;
	// One driver for the whole pin bundle, fields in declared order.
	assign pins_in = {cs_n, si_line, hold_n, wp_n};

	sfh_pin_io i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.spi_clk(spi_clk), .pins_in(pins_in), .pins_out(pins_out),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .dual_mode(dual_mode),
		.op_busy(op_busy), .status(status));
	sfh_host i_host (.spi_clk(spi_clk), .cs_n(cs_n), .si_drv(si_drv),
		.hold_n(hold_n), .pins_out(pins_out));

	// Core clock of 50 ns.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = !core_clk;
	end

	// A hang is cut short well beyond what the run needs.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d.", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Inputs change a fixed 2 ns after the edge, clear of sampling.
	task automatic wait_c(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	// Holds the word until the buffer takes it; caller drops valid.
	task automatic push(input logic [7:0] w);
		tx_data = w;
		tx_valid = 1'b1;
		do @(posedge core_clk); while (tx_ready !== 1'b1);
		#2;
	endtask

	task automatic wait_rx;
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 20) begin
			wait_c(1);
			k++;
		end
		`CHK(rx_valid, 1'b1)
	endtask

	task automatic t_rx;
		i_host.frame(1'b1);
		i_host.xfer(8'ha5, 8);
		wait_rx();
		`CHK(rx_data, 8'ha5)
		i_host.frame(1'b0);
	endtask

	// Pause mid-byte while a self-timed operation runs, then deselect.
	task automatic t_hold;
		wait_c(1);
		op_busy = 1'b1;
		i_host.frame(1'b1);
		i_host.xfer(8'h3c, 4);
		wait_rx();
		`CHK(rx_data, 8'h3c)
		i_host.frame(1'b0);
		wait_c(8);
		`CHK(status.standby, 1'b0)
		op_busy = 1'b0;
		wait_c(8);
		`CHK(status.standby, 1'b1)
	endtask

	// Fill buffer and mailbox with the clock stopped, then drain them.
	task automatic t_tx(input logic dm);
		logic [7:0] w;
		int per;
		per = dm ? 2 : 1;
		wait_c(1);
		dual_mode = dm;
		i_host.frame(1'b1);
		wait_c(5);
		for (int i = 0; i < 5; i++) begin
			push(8'h96 + 8'(i * 37));
		end
		tx_valid = 1'b0;
		wait_c(1);
		`CHK(tx_ready, 1'b0)
		i_host.hi_q.delete();
		i_host.lo_q.delete();
		repeat (8) i_host.xfer(8'h00, 8);
		`CHK(i_host.hi_q.size(), 40 / per)
		for (int i = 0; i < 5; i++) begin
			w = 8'h96 + 8'(i * 37);
			for (int p = 0; p < 8 / per; p++) begin
				`CHK(i_host.hi_q[i * 8 / per + p], w[7 - per * p])
				if (dm) begin
					`CHK(i_host.lo_q[i * 4 + p], w[6 - 2 * p])
				end
			end
		end
		i_host.frame(1'b0);
		wait_c(2);
		`CHK(pins_out.dual_line_high_oe_n, 1'b1)
	endtask

	task automatic t_wp;
		wp_n = 1'b0;
		wait_c(6);
		`CHK(status.wp_lock, 1'b1)
		wp_n = 1'b1;
		wait_c(6);
		`CHK(status.wp_lock, 1'b0)
	endtask

	// Main sequence; inputs start idle with reset applied.
	initial begin
		sys_rst = 1'b1;
		wp_n = 1'b1;
		tx_valid = 1'b0;
		dual_mode = 1'b0;
		op_busy = 1'b0;
		tx_data = 8'h00;
		wait_c(2);
		sys_rst = 1'b0;
		wait_c(4);
		t_rx();
		t_hold();
		t_tx(1'b0);
		t_tx(1'b1);
		t_wp();
		end_sim();
	end
endmodule // tb
